// >>> rtl/pie_consts.svh
// Register offsets, reset values and field positions for the peripheral interrupt enable block
`ifndef PIE_CONSTS_SVH
`define PIE_CONSTS_SVH
`define EN_REG_A_ADDR 8'h00
`define EN_REG_B_ADDR 8'h04
`define CTRL_REG_ADDR 8'h08
`define FLAG_REG_ADDR 8'h0C
`define PEND_REG_ADDR 8'h10
`define EN_RESET 8'h00
`define CTRL_RESET 8'h00
`define GATE_BIT 6
`define NUM_SOURCES 14
`define REG_WIDTH 8
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`endif

// >>> rtl/pie_pkg.sv
// Types shared by the peripheral interrupt enable block
package pie_pkg;
	typedef logic [7:0] byte_reg_t;
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_WRITE = 2'b01,
		ACC_READ = 2'b10
	} acc_state_t;
endpackage

// >>> rtl/enable_reg.sv
// One 8-bit software writable enable register with implemented-bit mask
`timescale 1ns/100ps
`include "pie_consts.svh"
module enable_reg
	import pie_pkg::*;
#(
	parameter logic [7:0] IMPL_MASK = 8'hFF
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] q_o
);
	byte_reg_t val_r;
	byte_reg_t val_nxt;

	// Only implemented positions store; the rest stay zero
	assign val_nxt = wdata_i & IMPL_MASK;

	// Clear at reset, load on write
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			val_r <= `EN_RESET;
		end else if (ce_i && wr_i) begin
			val_r <= val_nxt;
		end
	end

	assign q_o = val_r;
endmodule

// >>> rtl/periph_irq_enable.sv
// Peripheral interrupt enable registers, global gate and AHB-Lite slave
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pie_consts.svh"
module periph_irq_enable
	import pie_pkg::*;
#(
	parameter int POS_TIMER_ONE = 0,
	parameter int POS_TIMER_TWO = 1,
	parameter int POS_CAPCMP_A = 2,
	parameter int POS_SYNC_SERIAL = 3,
	parameter int POS_ASYNC_TX = 4,
	parameter int POS_ASYNC_RX = 5,
	parameter int POS_ADC = 6,
	parameter int POS_PARALLEL = 7,
	parameter int POS_CAPCMP_B = 8,
	parameter int POS_SLOPE_TRIP = 9,
	parameter int POS_SLOPE_OVF = 10,
	parameter int POS_EEPROM = 11,
	parameter int POS_LCD = 12,
	parameter int POS_COMPARATOR = 13
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [13:0] periph_flags_i,
	output logic core_irq_o
);
	// Source order: timer one, timer two, capcmp a, sync serial, async tx, async rx,
	// adc, parallel, capcmp b, slope trip, slope ovf, eeprom, lcd, comparator
	localparam int NSRC = `NUM_SOURCES;
	localparam int POS [NSRC] = '{POS_TIMER_ONE, POS_TIMER_TWO, POS_CAPCMP_A, POS_SYNC_SERIAL,
		POS_ASYNC_TX, POS_ASYNC_RX, POS_ADC, POS_PARALLEL, POS_CAPCMP_B, POS_SLOPE_TRIP,
		POS_SLOPE_OVF, POS_EEPROM, POS_LCD, POS_COMPARATOR};

	// Implemented-bit masks built from the placement parameters
	function automatic logic [15:0] impl_mask();
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < NSRC; i++) begin
			m[POS[i]] = 1'b1;
		end
		return m;
	endfunction
	localparam logic [15:0] MASK = impl_mask();
	// Only the global gate position exists in the control register
	localparam logic [7:0] GATE_MASK = 8'h01 << `GATE_BIT;

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite address phase capture
	acc_state_t acc_r;
	acc_state_t acc_nxt;
	logic [7:0] addr_r;
	wire logic take_w;
	assign take_w = hsel_i && hready_i && (htrans_i == `HTRANS_NONSEQ || htrans_i == `HTRANS_SEQ);

	// Next access kind from the address phase
	always_comb begin
		case ({take_w, hwrite_i})
			2'b11: acc_nxt = ACC_WRITE;
			2'b10: acc_nxt = ACC_READ;
			default: acc_nxt = ACC_IDLE;
		endcase
	end

	// Register the address phase
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			acc_r <= ACC_IDLE;
			addr_r <= 8'h00;
		end else if (ce_i && hready_i) begin
			acc_r <= acc_nxt;
			addr_r <= haddr_i;
		end
	end

	// Zero wait states, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Enable registers and control register
	wire logic wr_a_w;
	wire logic wr_b_w;
	wire logic wr_ctrl_w;
	wire logic [7:0] en_a_w;
	wire logic [7:0] en_b_w;
	logic [7:0] ctrl_r;
	assign wr_a_w = (acc_r == ACC_WRITE) && (addr_r == `EN_REG_A_ADDR);
	assign wr_b_w = (acc_r == ACC_WRITE) && (addr_r == `EN_REG_B_ADDR);
	assign wr_ctrl_w = (acc_r == ACC_WRITE) && (addr_r == `CTRL_REG_ADDR);

	// Two 8-bit enable registers hold all sources
	enable_reg #(.IMPL_MASK(MASK[7:0])) u_en_a (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.wr_i(wr_a_w),
		.wdata_i(hwdata_i[7:0]),
		.q_o(en_a_w)
	);
	enable_reg #(.IMPL_MASK(MASK[15:8])) u_en_b (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.wr_i(wr_b_w),
		.wdata_i(hwdata_i[7:0]),
		.q_o(en_b_w)
	);

	// Only the gate bit is implemented in the control register
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_r <= `CTRL_RESET;
		end else if (ce_i && wr_ctrl_w) begin
			ctrl_r <= hwdata_i[7:0] & (8'h01 << `GATE_BIT);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Enable mapping and request logic
	wire logic [15:0] en_all_w;
	wire logic gate_w;
	logic [NSRC-1:0] src_en_w;
	wire logic [NSRC-1:0] pend_w;
	wire logic irq_nxt;
	logic irq_r;
	assign en_all_w = {en_b_w, en_a_w};
	assign gate_w = ctrl_r[`GATE_BIT];

	// Pick each source's enable from its configured position
	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			src_en_w[i] = en_all_w[POS[i]];
		end
	end

	assign pend_w = periph_flags_i & src_en_w;
	assign irq_nxt = gate_w && (|pend_w);

	// Registered request to the core
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_r <= 1'b0;
		end else if (ce_i) begin
			irq_r <= irq_nxt;
		end
	end
	assign core_irq_o = irq_r;

	////////////////////////////////////////////////////////////////////////////
	// Read data, loaded into flops at the end of the address phase
	// A write landing on that same edge is forwarded, so a pipelined read sees it
	wire logic rd_take_w;
	wire logic [7:0] en_a_fwd_w;
	wire logic [7:0] en_b_fwd_w;
	wire logic [7:0] ctrl_fwd_w;
	wire logic [7:0] rd_w;
	wire logic [31:0] rdata_nxt;
	logic [31:0] hrdata_r;
	assign rd_take_w = take_w && !hwrite_i;
	assign en_a_fwd_w = wr_a_w ? (hwdata_i[7:0] & MASK[7:0]) : en_a_w;
	assign en_b_fwd_w = wr_b_w ? (hwdata_i[7:0] & MASK[15:8]) : en_b_w;
	assign ctrl_fwd_w = wr_ctrl_w ? (hwdata_i[7:0] & GATE_MASK) : ctrl_r;
	// Status words are live levels and are not forwarded
	assign rd_w = (haddr_i == `EN_REG_A_ADDR) ? en_a_fwd_w :
		(haddr_i == `EN_REG_B_ADDR) ? en_b_fwd_w :
		(haddr_i == `CTRL_REG_ADDR) ? ctrl_fwd_w :
		(haddr_i == `FLAG_REG_ADDR) ? periph_flags_i[7:0] :
		(haddr_i == `PEND_REG_ADDR) ? {2'b00, pend_w[13:8]} : 8'h00;
	assign rdata_nxt = rd_take_w ? {24'h000000, rd_w} : 32'h00000000;

	// Zero outside the data phase of a read
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hrdata_r <= 32'h00000000;
		end else if (ce_i && hready_i) begin
			hrdata_r <= rdata_nxt;
		end
	end
	assign hrdata_o = hrdata_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_gate_blocks: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && !gate_w |=> !core_irq_o) else $error("request passed closed gate");
	a_irq_cause: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && gate_w && (|(periph_flags_i & src_en_w)) |=> core_irq_o) else $error("request missed");
	a_irq_needs_en: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && (src_en_w == '0) |=> !core_irq_o) else $error("request without enable");
	a_write_a_sticks: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && wr_a_w |=> en_a_w == ($past(hwdata_i[7:0]) & MASK[7:0])) else $error("enable a write lost");
	a_write_b_sticks: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && wr_b_w |=> en_b_w == ($past(hwdata_i[7:0]) & MASK[15:8])) else $error("enable b write lost");
	a_unimpl_zero: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(en_all_w & ~MASK) == 16'h0000 && (ctrl_r & ~GATE_MASK) == 8'h00)
		else $error("unimplemented bit set");
	a_en_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!wr_a_w && !wr_b_w |=> $stable(en_all_w)) else $error("enable changed without write");
	a_map_pos: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		src_en_w[0] == en_all_w[POS_TIMER_ONE] && src_en_w[13] == en_all_w[POS_COMPARATOR])
		else $error("enable placement wrong");
	a_two_regs: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wr_a_w |=> $stable(en_b_w)) else $error("write to enable a changed enable b");
	a_ce_freeze: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(en_all_w) && $stable(ctrl_r) && $stable(core_irq_o) && $stable(hrdata_o))
		else $error("state moved while clock enable low");
	a_read_idle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && hready_i && !rd_take_w |=> hrdata_o == 32'h00000000) else $error("read data outside read phase");
	a_read_en_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		ce_i && rd_take_w && !wr_a_w && haddr_i == `EN_REG_A_ADDR |=> hrdata_o == {24'h000000, $past(en_a_w)})
		else $error("enable a read wrong");
	c_irq_raise: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) $rose(core_irq_o));
	c_freeze_access: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) !ce_i && take_w);
	c_gate_write: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) wr_ctrl_w);
	c_read_a: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) acc_r == ACC_READ && addr_r == 8'h00);
endmodule

// >>> dv/flag_sources.sv
// Peripheral flag sources standing at the far side of the enable block
`timescale 1ns/100ps
module flag_sources (
	input wire logic clk_sys_i,
	input wire logic [13:0] want_i,
	input wire logic slow_i,
	output logic [13:0] flags_o
);
	logic [13:0] lag_r;
	// Late copy of the requested flag levels
	always_ff @(posedge clk_sys_i) begin
		lag_r <= want_i;
	end
	// Flags are levels, raised at once or one cycle late
	assign flags_o = slow_i ? lag_r : want_i;
endmodule

// >>> dv/test_peripheral_interrupt_enable.sv
// Self-checking bench for the peripheral interrupt enable block
`timescale 1ns/100ps
`include "pie_consts.svh"
module test_peripheral_interrupt_enable
	import pie_pkg::*;
;
	logic clk_sys_i = 0, reset_n_i = 0, ce_i = 0, hsel_i = 0, hwrite_i = 0, slow = 0;
	logic [7:0] haddr_i = 8'h00;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] hwdata_i = 32'h0, hrdata_o, rd, w;
	logic hreadyout_o, hresp_o, core_irq_o;
	logic [13:0] want = 14'h0, flags;
	logic [7:0] last_a;
	logic [7:0] addrs [4] = '{`EN_REG_A_ADDR, `EN_REG_B_ADDR, `CTRL_REG_ADDR, 8'h14};
	logic [7:0] masks [4] = '{8'hFF, 8'h3F, 8'h40, 8'h00};
	int fails = 0, n_tests = 0;
	always #20 clk_sys_i = ~clk_sys_i;
	flag_sources far (.clk_sys_i(clk_sys_i), .want_i(want), .slow_i(slow), .flags_o(flags));
	periph_irq_enable DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.periph_flags_i(flags), .core_irq_o(core_irq_o));
	////////////////////////////////////////////////////////////////
	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One single AHB-Lite transfer, read data kept in rd
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= `HTRANS_NONSEQ;
		haddr_i <= a;
		hwrite_i <= wr;
		do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
		check({31'h0, hresp_o}, 32'h0);
	endtask
	// Program enables and gate, raise flags, compare request with the model
	task apply(input logic [13:0] e, input logic [13:0] f, input logic g);
		xfer(1'b1, `EN_REG_A_ADDR, {24'h0, e[7:0]});
		xfer(1'b1, `EN_REG_B_ADDR, {26'h0, e[13:8]});
		xfer(1'b1, `CTRL_REG_ADDR, {25'h0, g, 6'h0});
		last_a = e[7:0];
		want <= f;
		repeat (3) @(posedge clk_sys_i);
		check({31'h0, core_irq_o}, {31'h0, g & (|(f & e))});
		xfer(1'b0, `FLAG_REG_ADDR, 32'h0);
		check(rd, {24'h0, f[7:0]});
		xfer(1'b0, `PEND_REG_ADDR, 32'h0);
		check(rd, {26'h0, f[13:8] & e[13:8]});
	endtask
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Watchdog against a hung bus
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fails++;
		give_verdict();
	end
	// Main sequence
	initial begin
		void'($urandom(97));
		repeat (10) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		ce_i <= 1'b1;
		@(posedge clk_sys_i);
		// Reset value, random write, masked read back, unmapped place too
		for (int k = 0; k < 4; k++) begin
			xfer(1'b0, addrs[k], 32'h0);
			check(rd, 32'h0);
			w = $urandom;
			xfer(1'b1, addrs[k], w);
			xfer(1'b0, addrs[k], 32'h0);
			check(rd, w & {24'h0, masks[k]});
		end
		// Each source alone, gate off and on, then blocked by its own enable
		for (int s = 0; s < 14; s++) begin
			for (int g = 0; g < 2; g++) begin
				apply(14'h1 << s, 14'h1 << s, g[0]);
			end
			apply(14'h1 << s, ~(14'h1 << s), 1'b1);
			apply(~(14'h1 << s), 14'h1 << s, 1'b1);
		end
		// Random mixes, flags prompt or late
		for (int k = 0; k < 40; k++) begin
			slow <= k[0];
			apply(14'($urandom), 14'($urandom), 1'($urandom));
		end
		// Clock enable low freezes a write
		ce_i <= 1'b0;
		xfer(1'b1, `EN_REG_A_ADDR, {24'h0, ~last_a});
		ce_i <= 1'b1;
		xfer(1'b0, `EN_REG_A_ADDR, 32'h0);
		check(rd, {24'h0, last_a});
		// Reset in mid-run clears enables, gate and request
		want <= 14'h3FFF;
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		check({31'h0, core_irq_o}, 32'h0);
		reset_n_i <= 1'b1;
		@(posedge clk_sys_i);
		for (int k = 0; k < 3; k++) begin
			xfer(1'b0, addrs[k], 32'h0);
			check(rd, 32'h0);
		end
		check({31'h0, core_irq_o}, 32'h0);
		give_verdict();
	end
endmodule
